//--- hdl/framer_pkg.sv
// ==========================================================================
// shared constants for the correlation header framer
// ==========================================================================
package framer_pkg;

  // ========================================================================
  // widths and table size
  // ========================================================================
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned LEN_W   = 16;
  localparam int unsigned SEQ_W   = 16;
  localparam int unsigned ID_W    = 32;
  localparam int unsigned TUNNELS = 4;
  localparam int unsigned TUN_W   = 2;
  localparam int unsigned IDX_W   = 5;

  // ========================================================================
  // header layout: octet positions counted from zero
  // ========================================================================
  localparam logic [IDX_W-1:0] HDR_LEN      = 5'h14;  // 20 octets
  localparam logic [IDX_W-1:0] OCT_FLAGS    = 5'h00;
  localparam logic [IDX_W-1:0] OCT_MSG_TYPE = 5'h01;
  localparam logic [IDX_W-1:0] OCT_LEN_HI   = 5'h02;
  localparam logic [IDX_W-1:0] OCT_LEN_LO   = 5'h03;
  localparam logic [IDX_W-1:0] OCT_SEQ_HI   = 5'h04;
  localparam logic [IDX_W-1:0] OCT_SEQ_LO   = 5'h05;
  localparam logic [IDX_W-1:0] OCT_ZERO_LO  = 5'h06;
  localparam logic [IDX_W-1:0] OCT_ZERO_HI  = 5'h07;
  localparam logic [IDX_W-1:0] OCT_ONES_LO  = 5'h08;
  localparam logic [IDX_W-1:0] OCT_ONES_HI  = 5'h0B;
  localparam logic [IDX_W-1:0] OCT_CHG_LO   = 5'h0C;
  localparam logic [IDX_W-1:0] OCT_CHG_HI   = 5'h0F;
  localparam logic [IDX_W-1:0] OCT_GW_LO    = 5'h10;

  // ========================================================================
  // field values
  // ========================================================================
  localparam logic [2:0]        HDR_VERSION = 3'h0;
  localparam logic [2:0]        FLAG_FIXED  = 3'h7;   // bit 5 one, spares one
  localparam logic              FLAG_LSB    = 1'h0;
  localparam logic [BYTE_W-1:0] MSG_TYPE    = 8'hFF;
  localparam logic [BYTE_W-1:0] FILL_ZERO   = 8'h00;
  localparam logic [BYTE_W-1:0] FILL_ONES   = 8'hFF;

  // ========================================================================
  // reset values and sequence step
  // ========================================================================
  localparam logic [SEQ_W-1:0]  SEQ_RESET  = 16'h0000;
  localparam logic [SEQ_W-1:0]  SEQ_STEP   = 16'h0001;
  localparam logic [IDX_W-1:0]  IDX_RESET  = 5'h00;
  localparam logic [LEN_W-1:0]  LEN_RESET  = 16'h0000;
  localparam logic [ID_W-1:0]   ID_RESET   = 32'h0000_0000;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;

  // ========================================================================
  // framer states
  // ========================================================================
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR  = 2'b01,
    ST_PAY  = 2'b10
  } frame_state_t;

endpackage

//--- hdl/tunnel_seq_table.sv
`timescale 1ns/100ps
// ==========================================================================
// per-tunnel sequence counters, one flip-flop word per tunnel
// ==========================================================================
module tunnel_seq_table (
  // clock and reset
  input  wire logic                             ref_clk,
  input  wire logic                             rst_n,
  // lookup
  input  wire logic [framer_pkg::TUN_W-1:0]     rd_idx,
  output logic      [framer_pkg::SEQ_W-1:0]     rd_seq,
  // advance after a message leaves
  input  wire logic                             bump,
  input  wire logic [framer_pkg::TUN_W-1:0]     bump_idx
);

  logic [framer_pkg::SEQ_W-1:0] seq_ff     [framer_pkg::TUNNELS];
  logic [framer_pkg::SEQ_W-1:0] nxt_seq    [framer_pkg::TUNNELS];

  // read the addressed counter
  assign rd_seq = seq_ff[rd_idx];

  // ========================================================================
  // one counter per tunnel
  // ========================================================================
  for (genvar g = 0; g < framer_pkg::TUNNELS; g++) begin : g_tun
    // count once per message, wrapping from all ones to zero
    always_comb begin
      nxt_seq[g] = seq_ff[g];
      if (bump && (bump_idx == framer_pkg::TUN_W'(g))) begin
        nxt_seq[g] = seq_ff[g] + framer_pkg::SEQ_STEP;
      end
    end

    // register the counter
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        seq_ff[g] <= framer_pkg::SEQ_RESET;
      end else begin
        seq_ff[g] <= nxt_seq[g];
      end
    end
  end

endmodule // tunnel_seq_table

//--- hdl/correlation_header_framer.sv
`timescale 1ns/100ps
// How it works
// - version field in octet 1 is zero
// - octet 1 bit5 one, spares one, bit1 zero
// - bit 2 of octet 1 carries uplink flag
// - octet 2 always holds message type 255
// - payload length in octets 3-4, MSB first
// - per-tunnel increasing sequence in octets 5-6
// - eight-octet correlation number in octets 13-20
// - charge id then gateway node id
// - exactly one element follows each header
// - element is the packet, copied unmodified
// - framed packet handed to UDP/TCP transport
// - no retransmission or buffering for receiver
module correlation_header_framer (
  // clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              rst_n,
  // intercepted packet stream, metadata held with the packet
  input  wire logic                              in_valid,
  input  wire logic [framer_pkg::BYTE_W-1:0]     in_data,
  input  wire logic                              in_last,
  output logic                                   in_ready,
  input  wire logic                              pkt_uplink,
  input  wire logic [framer_pkg::LEN_W-1:0]      pkt_length,
  input  wire logic [framer_pkg::TUN_W-1:0]      pkt_tunnel,
  input  wire logic [framer_pkg::ID_W-1:0]       session_charge_id,
  input  wire logic [framer_pkg::ID_W-1:0]       gateway_node_id,
  // framed stream toward the transport
  output logic                                   out_valid,
  output logic [framer_pkg::BYTE_W-1:0]          out_data,
  output logic                                   out_last,
  input  wire logic                              out_ready,
  // status
  output logic                                   busy
);

  // ========================================================================
  // state
  // ========================================================================
  framer_pkg::frame_state_t              state_ff,    nxt_state;
  logic [framer_pkg::IDX_W-1:0]          idx_ff,      nxt_idx;
  logic                                  uplink_ff,   nxt_uplink;
  logic [framer_pkg::LEN_W-1:0]          len_ff,      nxt_len;
  logic [framer_pkg::SEQ_W-1:0]          seq_ff,      nxt_seq;
  logic [framer_pkg::TUN_W-1:0]          tun_ff,      nxt_tun;
  logic [framer_pkg::ID_W-1:0]           charge_ff,   nxt_charge;
  logic [framer_pkg::ID_W-1:0]           gw_ff,       nxt_gw;
  logic                                  out_valid_ff, nxt_out_valid;
  logic [framer_pkg::BYTE_W-1:0]         out_data_ff, nxt_out_data;
  logic                                  out_last_ff, nxt_out_last;
  logic                                  in_ready_ff, nxt_in_ready;
  logic                                  busy_ff,     nxt_busy;
  logic                                  bump;
  logic [framer_pkg::SEQ_W-1:0]          tun_seq;
  logic                                  slot_free;
  logic                                  take_in;

  // ========================================================================
  // header octet builder
  // ========================================================================
  function automatic logic [framer_pkg::BYTE_W-1:0] hdr_byte(
    input logic [framer_pkg::IDX_W-1:0] idx,
    input logic                         up,
    input logic [framer_pkg::LEN_W-1:0] len,
    input logic [framer_pkg::SEQ_W-1:0] seq,
    input logic [framer_pkg::ID_W-1:0]  chg,
    input logic [framer_pkg::ID_W-1:0]  gw
  );
    logic [1:0] sel;
    sel = idx[1:0];
    if (idx == framer_pkg::OCT_FLAGS) begin
      hdr_byte = {framer_pkg::HDR_VERSION,
                  framer_pkg::FLAG_FIXED,
                  up,
                  framer_pkg::FLAG_LSB};
    end else if (idx == framer_pkg::OCT_MSG_TYPE) begin
      hdr_byte = framer_pkg::MSG_TYPE;
    end else if (idx == framer_pkg::OCT_LEN_HI) begin
      hdr_byte = len[15:8];
    end else if (idx == framer_pkg::OCT_LEN_LO) begin
      hdr_byte = len[7:0];
    end else if (idx == framer_pkg::OCT_SEQ_HI) begin
      hdr_byte = seq[15:8];
    end else if (idx == framer_pkg::OCT_SEQ_LO) begin
      hdr_byte = seq[7:0];
    end else if (idx <= framer_pkg::OCT_ZERO_HI) begin
      hdr_byte = framer_pkg::FILL_ZERO;
    end else if (idx <= framer_pkg::OCT_ONES_HI) begin
      hdr_byte = framer_pkg::FILL_ONES;
    end else if (idx <= framer_pkg::OCT_CHG_HI) begin
      // charge id, most significant octet first
      hdr_byte = chg[8*(3-sel) +: 8];
    end else begin
      // gateway node id closes the correlation number
      hdr_byte = gw[8*(3-sel) +: 8];
    end
  endfunction

  // ========================================================================
  // per-tunnel sequence numbers
  // ========================================================================
  tunnel_seq_table u_seq (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .rd_idx   (pkt_tunnel),
    .rd_seq   (tun_seq),
    .bump     (bump),
    .bump_idx (tun_ff)
  );

  // output slot is free when empty or being drained this cycle
  assign slot_free = !out_valid_ff || out_ready;
  assign take_in   = in_ready_ff && in_valid;

  // ========================================================================
  // next-state logic
  // ========================================================================
  always_comb begin
    nxt_state     = state_ff;
    nxt_idx       = idx_ff;
    nxt_uplink    = uplink_ff;
    nxt_len       = len_ff;
    nxt_seq       = seq_ff;
    nxt_tun       = tun_ff;
    nxt_charge    = charge_ff;
    nxt_gw        = gw_ff;
    nxt_out_valid = out_valid_ff && !out_ready;
    nxt_out_data  = out_data_ff;
    nxt_out_last  = out_last_ff && !out_ready;
    nxt_in_ready  = 1'b0;
    bump          = 1'b0;
    unique case (state_ff)
      framer_pkg::ST_IDLE: begin
        // a waiting packet opens a new message; capture its metadata
        if (in_valid) begin
          nxt_state  = framer_pkg::ST_HDR;
          nxt_idx    = framer_pkg::IDX_RESET;
          nxt_uplink = pkt_uplink;
          nxt_len    = pkt_length;
          nxt_tun    = pkt_tunnel;
          nxt_seq    = tun_seq;
          nxt_charge = session_charge_id;
          nxt_gw     = gateway_node_id;
        end
      end
      framer_pkg::ST_HDR: begin
        // one header octet per free output slot
        if (slot_free) begin
          nxt_out_valid = 1'b1;
          nxt_out_last  = 1'b0;
          nxt_out_data  = hdr_byte(idx_ff, uplink_ff, len_ff, seq_ff, charge_ff, gw_ff);
          nxt_idx       = idx_ff + 5'h01;
          if (nxt_idx == framer_pkg::HDR_LEN) begin
            nxt_state    = framer_pkg::ST_PAY;
            nxt_in_ready = 1'b0;
          end
        end
      end
      framer_pkg::ST_PAY: begin
        // payload octets pass through untouched
        if (take_in) begin
          nxt_out_valid = 1'b1;
          nxt_out_data  = in_data;
          nxt_out_last  = in_last;
          if (in_last) begin
            // message done; the next packet gets a fresh header
            nxt_state = framer_pkg::ST_IDLE;
            bump      = 1'b1;
          end
        end else begin
          nxt_in_ready = !nxt_out_valid;
        end
      end
      default: begin
        nxt_state = framer_pkg::ST_IDLE;
      end
    endcase
    // accept payload only while the output slot will be empty, so a
    // stalled transport holds the source back and nothing is stored
    nxt_busy = (nxt_state != framer_pkg::ST_IDLE) || nxt_out_valid;
  end

  // ========================================================================
  // registers
  // ========================================================================
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= framer_pkg::ST_IDLE;
      idx_ff       <= framer_pkg::IDX_RESET;
      uplink_ff    <= 1'b0;
      len_ff       <= framer_pkg::LEN_RESET;
      seq_ff       <= framer_pkg::SEQ_RESET;
      tun_ff       <= '0;
      charge_ff    <= framer_pkg::ID_RESET;
      gw_ff        <= framer_pkg::ID_RESET;
      out_valid_ff <= 1'b0;
      out_data_ff  <= framer_pkg::BYTE_RESET;
      out_last_ff  <= 1'b0;
      in_ready_ff  <= 1'b0;
      busy_ff      <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      idx_ff       <= nxt_idx;
      uplink_ff    <= nxt_uplink;
      len_ff       <= nxt_len;
      seq_ff       <= nxt_seq;
      tun_ff       <= nxt_tun;
      charge_ff    <= nxt_charge;
      gw_ff        <= nxt_gw;
      out_valid_ff <= nxt_out_valid;
      out_data_ff  <= nxt_out_data;
      out_last_ff  <= nxt_out_last;
      in_ready_ff  <= nxt_in_ready;
      busy_ff      <= nxt_busy;
    end
  end

  // outputs straight from flops
  assign in_ready  = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data  = out_data_ff;
  assign out_last  = out_last_ff;
  assign busy      = busy_ff;

endmodule // correlation_header_framer

//--- bench/framer_checker.sv
`timescale 1ns/100ps
// ==========================================================================
// protocol checker for the framed output stream
// ==========================================================================
module framer_checker (
  // clock and reset
  input wire logic                          ref_clk,
  input wire logic                          rst_n,
  // intercepted stream and metadata
  input wire logic                          in_valid,
  input wire logic [framer_pkg::BYTE_W-1:0] in_data,
  input wire logic                          in_ready,
  input wire logic                          pkt_uplink,
  input wire logic [framer_pkg::LEN_W-1:0]  pkt_length,
  input wire logic [framer_pkg::ID_W-1:0]   session_charge_id,
  input wire logic [framer_pkg::ID_W-1:0]   gateway_node_id,
  // framed stream
  input wire logic                          out_valid,
  input wire logic [framer_pkg::BYTE_W-1:0] out_data,
  input wire logic                          out_last,
  input wire logic                          out_ready
);
  logic      [15:0] cnt_ff;
  logic      [15:0] nxt_cnt;
  logic      [15:0] len_ff;
  logic      [15:0] nxt_len;
  wire logic [63:0] corr = {session_charge_id, gateway_node_id};

  // octet index inside the current message, back to zero after the last one;
  // the length is kept from the first octet, as the source may move on early
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_len = len_ff;
    if (out_valid && out_ready) nxt_cnt = out_last ? 16'h0000 : cnt_ff + 16'h0001;
    if (out_valid && out_ready && cnt_ff == 16'h0000) nxt_len = pkt_length;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 16'h0000;
      len_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
      len_ff <= nxt_len;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_flag_version: assert property (out_valid && cnt_ff == 16'h0000
    |-> out_data[7:5] == 3'h0)
    else $error("version field not zero");
  a_flag_fixed: assert property (out_valid && cnt_ff == 16'h0000
    |-> out_data[4:2] == 3'h7 && !out_data[0])
    else $error("fixed flag bits wrong");
  a_dir_bit: assert property (out_valid && cnt_ff == 16'h0000 |-> out_data[1] == pkt_uplink)
    else $error("direction bit wrong");
  a_msg_type: assert property (out_valid && cnt_ff == 16'h0001 |-> out_data == 8'hFF)
    else $error("message type wrong");
  a_len_high: assert property (out_valid && cnt_ff == 16'h0002
    |-> out_data == pkt_length[15:8])
    else $error("length high octet wrong");
  a_fill_octets: assert property (out_valid && cnt_ff inside {[6:11]}
    |-> out_data == ((cnt_ff < 16'h0008) ? 8'h00 : 8'hFF))
    else $error("filler octet wrong");
  a_corr_ids: assert property (out_valid && cnt_ff inside {[12:19]}
    |-> out_data == corr[8*(19-cnt_ff[4:0]) +: 8])
    else $error("correlation octet wrong");
  a_last_place: assert property (out_valid && out_last
    |-> cnt_ff == len_ff + 16'h0013)
    else $error("last octet misplaced");
  a_ready_payload: assert property (in_ready |-> cnt_ff >= 16'h0014 && !out_valid)
    else $error("input taken outside payload");
  a_copy_byte: assert property (in_valid && in_ready
    |=> out_valid && out_data == $past(in_data))
    else $error("payload byte altered");
  a_hold_out: assert property (out_valid && !out_ready
    |=> out_valid && $stable(out_data) && $stable(out_last))
    else $error("pending octet dropped");

  c_stall: cover property (out_valid && !out_ready);
  c_last: cover property (out_valid && out_ready && out_last);
  c_uplink: cover property (out_valid && cnt_ff == 16'h0000 && pkt_uplink);
endmodule // framer_checker

bind correlation_header_framer framer_checker chk (.ref_clk, .rst_n, .in_valid, .in_data,
  .in_ready, .pkt_uplink, .pkt_length, .session_charge_id, .gateway_node_id, .out_valid,
  .out_data, .out_last, .out_ready);

//--- bench/transport_sink.sv
`timescale 1ns/100ps
// ==========================================================================
// transport-side receiver model
// ==========================================================================
module transport_sink (
  // clock
  input  wire logic       ref_clk,
  // stall control
  input  wire logic       slow,
  // framed stream
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  output logic            out_ready
);
  logic [8:0] got[$];

  initial out_ready = 1'b0;
  // store every accepted octet in arrival order with its last flag
  always @(posedge ref_clk) begin
    if (out_valid && out_ready) got.push_back({out_last, out_data});
  end
  // ready moves at the falling edge; a slow receiver refuses every other cycle
  always @(negedge ref_clk) out_ready <= slow ? !out_ready : 1'b1;
endmodule // transport_sink

//--- bench/intercept_correlation_header_framer_tb.sv
`timescale 1ns/100ps
// ==========================================================================
// self-checking bench for the correlation header framer
// ==========================================================================
module intercept_correlation_header_framer_tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        in_valid = 1'b0;
  logic        in_last = 1'b0;
  logic        pkt_uplink = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  in_data = 8'h00;
  logic [15:0] pkt_length = 16'h0000;
  logic [1:0]  pkt_tunnel = 2'h0;
  logic [31:0] session_charge_id = 32'h0000_0000;
  logic [31:0] gateway_node_id = 32'h0000_0000;
  logic        in_ready, out_valid, out_last, out_ready, busy;
  logic [7:0]  out_data;
  logic [8:0]  exp[$];
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;

  correlation_header_framer dut (.ref_clk, .rst_n, .in_valid, .in_data, .in_last, .in_ready,
    .pkt_uplink, .pkt_length, .pkt_tunnel, .session_charge_id, .gateway_node_id, .out_valid,
    .out_data, .out_last, .out_ready, .busy);
  transport_sink sink (.ref_clk, .slow, .out_valid, .out_data, .out_last, .out_ready);

  always #10 ref_clk = ~ref_clk;

  task automatic chk(input logic [8:0] g, input logic [8:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // queue the expected message, then feed the packet one byte per handshake
  task automatic send(input logic up, input logic [1:0] tn, input logic [31:0] cg,
                      input logic [31:0] gw, input logic [15:0] len, input logic [7:0] base,
                      input logic [15:0] sq);
    logic [159:0] hdr;
    logic         tk;
    int           i;
    hdr = {8'h1C | {6'h00, up, 1'b0}, 8'hFF, len, sq, 16'h0000, 32'hFFFF_FFFF, cg, gw};
    for (i = 0; i < 20; i++) exp.push_back({1'b0, hdr[159-8*i -: 8]});
    for (i = 0; i < len; i++) exp.push_back({i == len - 1, base + i[7:0]});
    pkt_uplink = up;
    pkt_tunnel = tn;
    session_charge_id = cg;
    gateway_node_id = gw;
    pkt_length = len;
    for (i = 0; i < len; i++) begin
      in_valid = 1'b1;
      in_data = base + i[7:0];
      in_last = (i == len - 1);
      tk = 1'b0;
      while (!tk) begin
        tk = in_ready;
        @(negedge ref_clk);
      end
    end
    chk({8'h00, busy}, 9'h001, "busy in message");
  endtask

  // wait for the receiver to hold every expected octet, then compare all
  task automatic drain(input string nm);
    int k;
    in_valid = 1'b0;
    for (k = 0; k < 2000 && sink.got.size() < exp.size(); k++) @(negedge ref_clk);
    repeat (4) @(negedge ref_clk);
    chk(9'(sink.got.size()), 9'(exp.size()), nm);
    for (k = 0; k < exp.size(); k++) begin
      chk(k < sink.got.size() ? sink.got[k] : 9'h1FF, exp[k], nm);
    end
    chk({8'h00, busy}, 9'h000, nm);
    exp.delete();
    sink.got.delete();
    $display("test %s done", nm);
  endtask

  task automatic t_basic;
    send(1'b0, 2'h0, 32'h1234_5678, 32'h9ABC_DEF0, 16'h0003, 8'h40, 16'h0000);
    drain("basic");
  endtask

  task automatic t_stall;
    slow = 1'b1;
    send(1'b1, 2'h1, 32'hA1B2_C3D4, 32'h0F1E_2D3C, 16'h0001, 8'hA5, 16'h0000);
    drain("stall");
    slow = 1'b0;
  endtask

  task automatic t_seq;
    send(1'b0, 2'h2, 32'h0000_0011, 32'h0000_0022, 16'h0002, 8'h10, 16'h0000);
    send(1'b1, 2'h2, 32'h0000_0011, 32'h0000_0022, 16'h0001, 8'h20, 16'h0001);
    send(1'b0, 2'h2, 32'h0000_0011, 32'h0000_0022, 16'h0102, 8'h30, 16'h0002);
    send(1'b1, 2'h0, 32'h1234_5678, 32'h9ABC_DEF0, 16'h0002, 8'h50, 16'h0001);
    drain("sequence");
  endtask

  // reset during a header, then the tunnel counter must start again at zero
  task automatic t_reset;
    pkt_tunnel = 2'h2;
    pkt_length = 16'h0004;
    in_valid = 1'b1;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b0;
    in_valid = 1'b0;
    @(negedge ref_clk);
    chk({6'h00, busy, out_valid, in_ready}, 9'h000, "reset idle");
    rst_n = 1'b1;
    sink.got.delete();
    @(negedge ref_clk);
    send(1'b0, 2'h2, 32'hCAFE_0001, 32'h0BAD_0002, 16'h0004, 8'h70, 16'h0000);
    drain("reset");
  endtask

  // cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      $display("mismatch %0t timeout", $time);
      conclude();
    end
  end

  initial begin
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    t_basic();
    t_stall();
    t_seq();
    t_reset();
    conclude();
  end
endmodule // intercept_correlation_header_framer_tb
